// File: logic/sleep_gate_map.vh
`ifndef SLEEP_GATE_MAP_VH
`define SLEEP_GATE_MAP_VH

// register byte addresses on the 12-bit window
`define RUN_GATE_OFF 12'h100
`define SLEEP_GATE_OFF 12'h110
`define DEEP_GATE_OFF 12'h120
`define RUN_CLK_CFG_OFF 12'h140
`define IRQ_STATUS_OFF 12'h150
`define IRQ_ENABLE_OFF 12'h154
`define IRQ_CLEAR_OFF 12'h158

// gating register layout
`define GATE_RESET 32'h00000040
`define GATE_IMPL_MASK 32'h00100048
`define PWM_BIT 20
`define KEEPER_BIT 6
`define WDOG_BIT 3

// run clock configuration layout
`define SEL_BIT 0
`define CFG_RESET 1'b0

// unit indexes on the per-unit vectors
`define UNIT_WDOG 0
`define UNIT_KEEPER 1
`define UNIT_PWM 2
`define UNIT_COUNT 3

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: logic/unit_clock_gate.v
`timescale 1ns/1ps
// glitch-free gate: enable is retimed on the falling edge so it can
// only change while the clock is low
module unit_clock_gate (
    // clock and reset
    input wire i_clock,
    input wire i_nrst,
    // gate control
    input wire i_enable,
    // gated clock
    output wire o_clock
);

reg enable_fall_reg;

// falling-edge retime keeps the high phase whole
always @(negedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        enable_fall_reg <= 1'b0;
    end else begin
        enable_fall_reg <= i_enable;
    end
end

assign o_clock = i_clock & enable_fall_reg;

endmodule // unit_clock_gate

// File: logic/fault_irq_status.v
`timescale 1ns/1ps
// sticky event bits, write-one-to-clear, enable mask, level interrupt
module fault_irq_status #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire i_clock,
    input wire i_nrst,
    // events and software control
    input wire [WIDTH-1:0] i_set,
    input wire [WIDTH-1:0] i_clear,
    input wire [WIDTH-1:0] i_enable,
    // state
    output reg [WIDTH-1:0] o_status,
    output wire o_irq
);

// a set in the same cycle as its clear wins, so no event is lost
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        o_status <= {WIDTH{1'b0}};
    end else begin
        o_status <= (o_status & ~i_clear) | i_set;
    end
end

assign o_irq = |(o_status & i_enable);

endmodule // fault_irq_status

// File: logic/sleep_clock_gating.v
`timescale 1ns/1ps
`include "sleep_gate_map.vh"

// Behaviour
// - set bit clocks unit, clear bit stops it
// - access to unclocked unit answers bus fault
// - gating bits reset clear except bit 6, set in all three gating registers
// - sleep register resets 0x40, bits read-write
// - run, sleep, deep-sleep registers per mode
// - sleep registers only apply with select set
// - bit 3 gates watchdog, faults when clear
// - reserved bits read zero, ignore writes
// - bit 6 gates low-power keeper unit
module sleep_clock_gating (
    // clock and reset
    input wire i_clock,
    input wire i_nrst,
    // axi4-lite write address
    input wire [11:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    // axi4-lite write data
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    // axi4-lite write response
    output wire [1:0] o_bresp,
    output wire o_bvalid,
    input wire i_bready,
    // axi4-lite read address
    input wire [11:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    // axi4-lite read data
    output wire [31:0] o_rdata,
    output wire [1:0] o_rresp,
    output wire o_rvalid,
    input wire i_rready,
    // power mode from the system controller
    input wire i_sleep,
    input wire i_deep_sleep,
    // unit side: access strobes, faults, clocks
    input wire [2:0] i_unit_access,
    output wire [2:0] o_unit_fault,
    output wire [2:0] o_unit_enable,
    output wire [2:0] o_unit_clock,
    // interrupt
    output wire o_irq
);

// write channel state
reg aw_full_reg;
reg [11:0] aw_addr_reg;
reg w_full_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg bvalid_reg;
reg [1:0] bresp_reg;
// read channel state
reg rvalid_reg;
reg [1:0] rresp_reg;
reg [31:0] rdata_reg;
// registers
reg [31:0] run_gate_reg0;
reg [31:0] sleep_gate_reg0;
reg [31:0] deep_sleep_gate_reg0;
reg sleep_gating_select_reg;
reg [2:0] irq_enable_reg;
reg [2:0] irq_clear_reg;
// effective gating
reg [31:0] active_gate_next;
reg [2:0] unit_enable_reg;
reg [2:0] unit_fault_reg;
wire [2:0] unit_bits;
wire [2:0] irq_status;
// read decode
reg [31:0] read_next;
reg read_hit;
// write decode
wire do_write;
wire [31:0] write_merged;
reg write_hit;

// byte-lane merge of the bus data into an old register value
function [31:0] merge_bytes;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strb;
    integer k;
    begin
        merge_bytes = old_value;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
                merge_bytes[k*8 +: 8] = new_value[k*8 +: 8];
            end
        end
    end
endfunction

// one write at a time: channels close until the response is taken
assign o_awready = !aw_full_reg && !bvalid_reg;
assign o_wready = !w_full_reg && !bvalid_reg;
assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
assign o_bvalid = bvalid_reg;
assign o_bresp = bresp_reg;

// address and data are caught separately, in either order
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        aw_full_reg <= 1'b0;
        aw_addr_reg <= 12'h000;
        w_full_reg <= 1'b0;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
    end else begin
        if (i_awvalid && o_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
        if (i_wvalid && o_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end
end

assign write_merged = merge_bytes(32'h00000000, w_data_reg, w_strb_reg);

// write address decode; the clear register is write-only but mapped
always @* begin
    case (aw_addr_reg)
        `RUN_GATE_OFF: write_hit = 1'b1;
        `SLEEP_GATE_OFF: write_hit = 1'b1;
        `DEEP_GATE_OFF: write_hit = 1'b1;
        `RUN_CLK_CFG_OFF: write_hit = 1'b1;
        `IRQ_STATUS_OFF: write_hit = 1'b1;
        `IRQ_ENABLE_OFF: write_hit = 1'b1;
        `IRQ_CLEAR_OFF: write_hit = 1'b1;
        default: write_hit = 1'b0;
    endcase
end

// write response; unmapped addresses answer slverr
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        bvalid_reg <= 1'b0;
        bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_bready) begin
        bvalid_reg <= 1'b0;
    end
end

// register updates; only implemented bits take the write
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        run_gate_reg0 <= `GATE_RESET;
        sleep_gate_reg0 <= `GATE_RESET;
        deep_sleep_gate_reg0 <= `GATE_RESET;
        sleep_gating_select_reg <= `CFG_RESET;
        irq_enable_reg <= 3'h0;
        irq_clear_reg <= 3'h0;
    end else begin
        irq_clear_reg <= 3'h0;
        if (do_write) begin
            case (aw_addr_reg)
                `RUN_GATE_OFF: begin
                    run_gate_reg0 <= merge_bytes(run_gate_reg0,
                        w_data_reg, w_strb_reg) & `GATE_IMPL_MASK;
                end
                `SLEEP_GATE_OFF: begin
                    // read-write gating bits
                    sleep_gate_reg0 <= merge_bytes(sleep_gate_reg0,
                        w_data_reg, w_strb_reg) & `GATE_IMPL_MASK;
                end
                `DEEP_GATE_OFF: begin
                    deep_sleep_gate_reg0 <= merge_bytes(
                        deep_sleep_gate_reg0, w_data_reg, w_strb_reg)
                        & `GATE_IMPL_MASK;
                end
                `RUN_CLK_CFG_OFF: begin
                    if (w_strb_reg[0]) begin
                        sleep_gating_select_reg <=
                            w_data_reg[`SEL_BIT];
                    end
                end
                `IRQ_ENABLE_OFF: begin
                    if (w_strb_reg[0]) begin
                        irq_enable_reg <= w_data_reg[2:0];
                    end
                end
                `IRQ_CLEAR_OFF: begin
                    // one-cycle pulse into the sticky bits
                    irq_clear_reg <= write_merged[2:0];
                end
                default: begin
                end
            endcase
        end
    end
end

// read mux; reserved bits are zero because they are never stored
always @* begin
    read_next = 32'h00000000;
    read_hit = 1'b1;
    case (i_araddr)
        `RUN_GATE_OFF: read_next = run_gate_reg0;
        `SLEEP_GATE_OFF: read_next = sleep_gate_reg0;
        `DEEP_GATE_OFF: read_next = deep_sleep_gate_reg0;
        `RUN_CLK_CFG_OFF: read_next[`SEL_BIT] = sleep_gating_select_reg;
        `IRQ_STATUS_OFF: read_next[2:0] = irq_status;
        `IRQ_ENABLE_OFF: read_next[2:0] = irq_enable_reg;
        `IRQ_CLEAR_OFF: read_next = 32'h00000000;
        default: read_hit = 1'b0;
    endcase
end

// one read at a time; data answers the edge after the address
assign o_arready = !rvalid_reg;
assign o_rvalid = rvalid_reg;
assign o_rresp = rresp_reg;
assign o_rdata = rdata_reg;

always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        rvalid_reg <= 1'b0;
        rresp_reg <= `RESP_OKAY;
        rdata_reg <= 32'h00000000;
    end else if (i_arvalid && o_arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
        rdata_reg <= read_next;
    end else if (i_rready) begin
        rvalid_reg <= 1'b0;
    end
end

// mode select: the sleep registers need the select bit, else the
// run register keeps governing through sleep
always @* begin
    if (i_deep_sleep && sleep_gating_select_reg) begin
        active_gate_next = deep_sleep_gate_reg0;
    end else if (i_sleep && sleep_gating_select_reg) begin
        active_gate_next = sleep_gate_reg0;
    end else begin
        active_gate_next = run_gate_reg0;
    end
end

// pick the three unit bits out of the selected register
assign unit_bits[`UNIT_WDOG] = active_gate_next[`WDOG_BIT];
assign unit_bits[`UNIT_KEEPER] = active_gate_next[`KEEPER_BIT];
assign unit_bits[`UNIT_PWM] = active_gate_next[`PWM_BIT];

// registered so the gate sees a clean level from a flip-flop
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        unit_enable_reg <= 3'h0;
    end else begin
        unit_enable_reg <= unit_bits;
    end
end

assign o_unit_enable = unit_enable_reg;

// an access to a stopped unit gets a fault instead of completing
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        unit_fault_reg <= 3'h0;
    end else begin
        unit_fault_reg <= i_unit_access & ~unit_enable_reg;
    end
end

assign o_unit_fault = unit_fault_reg;

// one glitch-free clock gate per unit
genvar g;
generate
    for (g = 0; g < `UNIT_COUNT; g = g + 1) begin : gate_gen
        unit_clock_gate gate_cell (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_enable(unit_enable_reg[g]),
            .o_clock(o_unit_clock[g])
        );
    end
endgenerate

// each fault is also a sticky event for software
fault_irq_status #(
    .WIDTH(`UNIT_COUNT)
) irq_block (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_set(unit_fault_reg),
    .i_clear(irq_clear_reg),
    .i_enable(irq_enable_reg),
    .o_status(irq_status),
    .o_irq(o_irq)
);

endmodule // sleep_clock_gating

// File: tb/unit_model.sv
`timescale 1ns/1ps
// stand-in for the three gated units, each counting the edges it receives
module unit_model (
    // gated clocks and count clear
    input wire logic [2:0] i_unit_clock,
    input wire logic i_clear,
    // edges seen per unit since the last clear, eight bits per unit
    output wire logic [23:0] o_count
);
    genvar u;
    // a unit only advances while clocked, so counts expose the gating
    for (u = 0; u < 3; u = u + 1) begin : g_unit
        logic [7:0] count;
        always @(posedge i_unit_clock[u] or posedge i_clear) begin
            if (i_clear)
                count <= 8'h0;
            else
                count <= count + 8'h1;
        end
        assign o_count[u*8 +: 8] = count;
    end
endmodule // unit_model

// File: tb/sleep_gate_asserts.sv
`timescale 1ns/1ps
`include "sleep_gate_map.vh"
// port-level checks on the gating block
module sleep_gate_asserts (
    // clock and reset
    input wire i_clock,
    input wire i_nrst,
    // bus handshakes
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire o_bvalid,
    input wire [11:0] i_araddr,
    input wire i_arvalid,
    input wire o_arready,
    input wire [31:0] o_rdata,
    input wire o_rvalid,
    input wire i_rready,
    // unit side
    input wire [2:0] i_unit_access,
    input wire [2:0] o_unit_fault,
    input wire [2:0] o_unit_enable,
    input wire [2:0] o_unit_clock
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // both halves of a write taken on one edge
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence
    property p_wr_answer;
        s_wr_taken |=> ##1 o_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> o_rvalid;
    endproperty
    property p_rd_hold;
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
    endproperty
    property p_reserved;
        s_rd_taken ##0 (i_araddr == `SLEEP_GATE_OFF)
            |=> (o_rdata & ~`GATE_IMPL_MASK) == 32'h0;
    endproperty
    property p_fault_off;
        i_unit_access[2] && !o_unit_enable[2] |=> o_unit_fault[2];
    endproperty
    property p_fault_on;
        i_unit_access[0] && o_unit_enable[0] |=> !o_unit_fault[0];
    endproperty
    property p_reset_enable;
        $rose(i_nrst) |=> o_unit_enable == 3'b010;
    endproperty
    // gate retimed on the falling edge, so look there
    property p_clock_runs;
        @(negedge i_clock) disable iff (!i_nrst)
            o_unit_enable[1] |=> o_unit_clock[1];
    endproperty
    property p_clock_stops;
        @(negedge i_clock) disable iff (!i_nrst)
            !o_unit_enable[2] |=> !o_unit_clock[2];
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data dropped");
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not zero");
    a_fault_off: assert property (p_fault_off)
        else $error("no fault on gated unit");
    a_fault_on: assert property (p_fault_on)
        else $error("fault on clocked unit");
    a_reset_enable: assert property (p_reset_enable)
        else $error("wrong enables after reset");
    a_clock_runs: assert property (p_clock_runs)
        else $error("enabled unit not clocked");
    a_clock_stops: assert property (p_clock_stops)
        else $error("disabled unit clocked");
endmodule // sleep_gate_asserts

bind sleep_clock_gating sleep_gate_asserts i_sleep_gate_asserts (.*);

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "sleep_gate_map.vh"
module testbench;
    logic i_clock = 0, i_nrst = 0, clr = 0;
    logic [11:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, rd, d;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic i_arvalid = 0, i_rready = 0, i_sleep = 0, i_deep_sleep = 0;
    logic [2:0] i_unit_access = 0, a, e;
    logic [1:0] rs;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [2:0] o_unit_fault, o_unit_enable, o_unit_clock;
    wire [23:0] cnt;
    int num_errors = 0, samples_checked = 0;
    sleep_clock_gating i_sleep_clock_gating (.*);
    unit_model i_unit_model (.i_unit_clock(o_unit_clock), .i_clear(clr),
        .o_count(cnt));
    initial begin
        forever #25 i_clock = ~i_clock;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ready sampled mid-cycle, so the edge decision never races
    task wr(input [11:0] ad, input [31:0] dv, output [1:0] r);
        int n;
        logic ra, rw, ta, tw;
        i_awaddr <= ad; i_wdata <= dv; i_awvalid <= 1; i_wvalid <= 1;
        ta = 0; tw = 0; n = 0;
        while (!(ta && tw)) begin
            @(negedge i_clock); ra = o_awready; rw = o_wready;
            @(posedge i_clock);
            if (ra && !ta) begin ta = 1; i_awvalid <= 0; end
            if (rw && !tw) begin tw = 1; i_wvalid <= 0; end
            if (++n > 40) begin num_errors++; final_report; end
        end
        i_bready <= 1;
        do begin
            @(negedge i_clock); ra = o_bvalid; r = o_bresp;
            @(posedge i_clock);
            if (++n > 80) begin num_errors++; final_report; end
        end while (!ra);
        i_bready <= 0;
    endtask
    task rdt(input [11:0] ad, output [31:0] dv, output [1:0] r);
        int n;
        logic ok;
        i_araddr <= ad; i_arvalid <= 1; n = 0;
        do begin
            @(negedge i_clock); ok = o_arready; @(posedge i_clock);
            if (++n > 40) begin num_errors++; final_report; end
        end while (!ok);
        i_arvalid <= 0;
        // late rready now and then, so held read data gets exercised
        repeat (2'($urandom % 3)) @(posedge i_clock);
        i_rready <= 1;
        do begin
            @(negedge i_clock); ok = o_rvalid; dv = o_rdata; r = o_rresp;
            @(posedge i_clock);
            if (++n > 80) begin num_errors++; final_report; end
        end while (!ok);
        i_rready <= 0;
    endtask
    // run 0x8 wdog, sleep 0x100000 pwm, deep 0x40 keeper
    function [2:0] en_exp(input int m);
        logic [31:0] g;
        g = !m[0] ? 32'h8 : m[2] ? 32'h40 : m[1] ? 32'h00100000 : 32'h8;
        return {g[20], g[6], g[3]};
    endfunction
    initial begin
        void'($urandom(7358));
        repeat (20) @(posedge i_clock);
        i_nrst <= 1;
        @(posedge i_clock); @(negedge i_clock);
        chk("reset enable", o_unit_enable, 3'b010);
        @(posedge i_clock);
        rdt(`SLEEP_GATE_OFF, rd, rs);
        chk("sleep reset", rd, 32'h40);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : $urandom;
            wr(`SLEEP_GATE_OFF, d, rs);
            chk("sleep bresp", rs, `RESP_OKAY);
            rdt(`SLEEP_GATE_OFF, rd, rs);
            chk("sleep rresp", rs, `RESP_OKAY);
            chk("sleep rw", rd, d & 32'h00100048);
        end
        $display("register test done");
        wr(`RUN_GATE_OFF, 32'h8, rs);
        wr(`SLEEP_GATE_OFF, 32'h00100000, rs);
        wr(`DEEP_GATE_OFF, 32'h40, rs);
        for (int m = 0; m < 8; m++) begin
            wr(`RUN_CLK_CFG_OFF, m & 1, rs);
            i_sleep <= m[1]; i_deep_sleep <= m[2];
            repeat (2) @(posedge i_clock);
            clr <= 1; @(posedge i_clock); clr <= 0;
            repeat (8) @(posedge i_clock); @(negedge i_clock);
            e = en_exp(m);
            chk("mode enable", o_unit_enable, e);
            for (int u = 0; u < 3; u++)
                chk("unit clock", cnt[u*8 +: 8] != 0, e[u]);
            @(posedge i_clock);
        end
        i_sleep <= 0; i_deep_sleep <= 0;
        $display("mode test done");
        wr(`RUN_GATE_OFF, 32'h0, rs);
        // a fault with the mask still clear must not raise the line
        i_unit_access <= 3'h1; @(posedge i_clock);
        i_unit_access <= 0; repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk("masked irq", o_irq, 1'b0);
        @(posedge i_clock);
        wr(`IRQ_ENABLE_OFF, 32'h7, rs);
        for (int k = 0; k < 4; k++) begin
            // first pass hits all three units at once
            a = k == 0 ? 3'h7 : 3'($urandom % 7 + 1);
            i_unit_access <= a; @(posedge i_clock);
            i_unit_access <= 0; @(negedge i_clock);
            chk("fault", o_unit_fault, a);
            @(posedge i_clock); @(negedge i_clock);
            chk("irq", o_irq, 1'b1);
            @(posedge i_clock);
            rdt(`IRQ_STATUS_OFF, rd, rs);
            chk("status", rd, a);
            wr(`IRQ_CLEAR_OFF, 32'h7, rs);
            rdt(`IRQ_STATUS_OFF, rd, rs);
            chk("cleared", rd, 32'h0);
            chk("irq cleared", o_irq, 1'b0);
        end
        wr(`RUN_GATE_OFF, 32'h00100048, rs); // units enabled first
        repeat (2) @(posedge i_clock);
        i_unit_access <= 3'h7; @(posedge i_clock);
        i_unit_access <= 0; @(negedge i_clock);
        chk("no fault", o_unit_fault, 3'h0);
        @(posedge i_clock);
        $display("fault test done");
        wr(12'h200, $urandom, rs);
        chk("unmapped bresp", rs, 2'b10);
        rdt(12'h204, rd, rs);
        chk("unmapped rresp", rs, 2'b10);
        chk("unmapped read", rd, 32'h0);
        $display("unmapped test done");
        final_report;
    end
endmodule // testbench
